// [rtl/rtsa_cmd_ctrl.sv]
// command handler for reset to ready and identifier write/lock requests
`timescale 1ns/1ps
`default_nettype none
`include "rtsa_regs.svh"
module rtsa_cmd_ctrl
   import rtsa_pkg::*;
#(
   parameter int WRITE_CYCLES = `RTSA_WRITE_CYCLES,
   parameter logic OPTION_SUPPORTED = 1'b1
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [7:0] req_flags,
   input wire logic [7:0] req_cmd,
   input wire logic req_uid_present,
   input wire logic [63:0] req_uid,
   input wire logic [7:0] req_data,
   input wire logic req_data_present,
   input wire logic req_frame_err,
   input wire logic [63:0] own_uid,
   input wire logic nv_fail_inject,
   output logic busy,
   output logic resp_valid,
   output logic [7:0] resp_flags,
   output logic resp_has_err,
   output logic [7:0] resp_err_code,
   output logic [2:0] proto_state,
   output logic [7:0] afi_value,
   output logic [7:0] dsfid_value,
   output logic afi_locked,
   output logic dsfid_locked
);
   initial begin
      if (WRITE_CYCLES < 1) $error("rtsa_cmd_ctrl: WRITE_CYCLES must be at least 1");
   end

   // reset released through two flops
   logic rst_s1_q, rst_s2_q;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   logic rst_core_n;
   assign rst_core_n = rst_s2_q;

   // sequencer state and the latched request
   rtsa_state_t st_q, st_d;
   rtsa_proto_t pst_q, pst_d;
   logic [7:0] cmd_q, cmd_d, data_q, data_d;
   logic [7:0] err_q, err_d, rflags_q, rflags_d;
   logic reserr_q, reserr_d, rvalid_q, rvalid_d;
   logic nv_wr, nv_sel_dsfid, nv_lock, nv_ok, tmr_start, tmr_done;
   logic [7:0] afi_w, dsfid_w;
   logic afi_lk_w, dsfid_lk_w;

   // identifier cells with their lock bits
   rtsa_nv_store u_store (
      .core_clk(core_clk),
      .rst_n(rst_core_n),
      .wr_en(nv_wr),
      .sel_dsfid(nv_sel_dsfid),
      .lock_op(nv_lock),
      .wr_data(data_q),
      .fail_inject(nv_fail_inject),
      .ok(nv_ok),
      .afi(afi_w),
      .dsfid(dsfid_w),
      .afi_locked(afi_lk_w),
      .dsfid_locked(dsfid_lk_w)
   );

   // write cycle timer, one load per program or lock
   rtsa_wait_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
      .core_clk(core_clk),
      .rst_n(rst_core_n),
      .start(tmr_start),
      .done(tmr_done)
   );

   // request decode helpers
   logic is_ours, addressed, uid_match, known_cmd, is_write, is_lock, tgt_dsfid;
   assign addressed = req_flags[`RTSA_FLAG_ADDRESS_BIT];
   // uid field optional; only compared when the request carries it
   assign uid_match = req_uid_present && (req_uid == own_uid);
   assign known_cmd = (req_cmd >= `RTSA_CMD_RESET_READY) && (req_cmd <= `RTSA_CMD_LOCK_DSFID);
   // an addressed request for another tag is dropped silently
   assign is_ours = known_cmd && (!addressed || uid_match);
   assign is_write = (cmd_q == `RTSA_CMD_WRITE_AFI) || (cmd_q == `RTSA_CMD_WRITE_DSFID);
   assign is_lock = (cmd_q == `RTSA_CMD_LOCK_AFI) || (cmd_q == `RTSA_CMD_LOCK_DSFID);
   assign tgt_dsfid = (cmd_q == `RTSA_CMD_WRITE_DSFID) || (cmd_q == `RTSA_CMD_LOCK_DSFID);

   // sequencer timing, counted from the edge that takes a request (e0)
   // e0: idle sees req_valid for this tag; command, data and intake checks latch
   // e0: busy rises with the same edge, so the reader holds off from e1 on
   // e1: exec decides; intake errors and reset to ready go straight to resp
   // e1: lock bits are read from the cells, not from the port mirrors
   // e1: a locked target answers at once without starting the write cycle
   // e1: otherwise the cell is written and the wait timer is loaded
   // e2 on: prog waits for the timer; the reply is held back all that time
   // the timer done pulse moves prog to done one edge later
   // done: the store's ok flag picks success or the lock or program failure code
   // done: success of a write or lock puts the tag back to ready
   // resp: one cycle; flags, error flag and code go out together next edge
   // resp: busy drops with the answer, so the next request may follow at once
   // an answer without a write cycle stands after e2; with one, after e(count+4)
   // a reset to ready without error always answers success with flags 00h
   // the error flag of the answer is bit 0 of the flags byte
   // hazards and limits
   // the cell changes at e1, long before the reply; a reader that modulates
   // during the cycle is not seen here, the far side must keep quiet itself
   // failure is modelled by the store keeping its old contents; a failed
   // lock leaves the lock bit clear so a later lock may still succeed
   // the store's ok flag is registered at the write edge and read in done,
   // so a later change of nv_fail_inject cannot alter the outcome
   // intake checks run in a fixed order: frame error, option, missing data;
   // only the first one that hits is reported, as a single code
   // addressed frames without a matching uid never leave idle, so no
   // error answer can reveal anything about another tag
   // unknown command codes are dropped in idle like foreign frames
   // requests seen while busy are ignored outright, not queued; the reader
   // side is expected to wait for busy low before it offers the next one
   // the command byte stays latched after the answer; decode helpers built
   // on it only matter while a command is in flight
   // the write cycle count is a parameter so that simulation can shorten it;
   // the default covers the nominal reply delay plus the eighteen periods
   // protocol state is only ever moved to ready here; select and quiet
   // belong to commands handled elsewhere in the tag
   // trade-off: one sequencer for all five commands saves area over one
   // per command, at the price of a shared error register
   // a cut frame arrives as req_frame_err and gets the generic code
   // no buffering: one request in flight, one answer; only the latched command, data, code and flags outlive it
   // the cell model resets to fixed values; a real array would keep them
   // command sequencer
   always_comb begin
      st_d = st_q;
      pst_d = pst_q;
      cmd_d = cmd_q;
      data_d = data_q;
      err_d = err_q;
      reserr_d = reserr_q;
      rflags_d = rflags_q;
      rvalid_d = 1'b0;
      nv_wr = 1'b0;
      nv_lock = is_lock;
      nv_sel_dsfid = tgt_dsfid;
      tmr_start = 1'b0;
      case (st_q)
         RTSA_IDLE: begin
            if (req_valid && is_ours) begin
               cmd_d = req_cmd;
               data_d = req_data;
               reserr_d = 1'b0;
               err_d = 8'h00;
               if (req_frame_err) begin
                  reserr_d = 1'b1;
                  err_d = `RTSA_ERR_GENERIC;
               end else if (req_flags[`RTSA_FLAG_OPTION_BIT] && !OPTION_SUPPORTED) begin
                  reserr_d = 1'b1;
                  err_d = `RTSA_ERR_OPTION;
               end else if ((req_cmd == `RTSA_CMD_WRITE_AFI ||
                             req_cmd == `RTSA_CMD_WRITE_DSFID) && !req_data_present) begin
                  reserr_d = 1'b1;
                  err_d = `RTSA_ERR_GENERIC;
               end
               st_d = RTSA_EXEC;
            end
         end
         RTSA_EXEC: begin
            if (reserr_q) begin
               st_d = RTSA_RESP;
            end else if (cmd_q == `RTSA_CMD_RESET_READY) begin
               pst_d = RTSA_PST_READY;
               st_d = RTSA_RESP;
            end else if (is_write && (tgt_dsfid ? dsfid_lk_w : afi_lk_w)) begin
               reserr_d = 1'b1;
               err_d = `RTSA_ERR_LOCKED;
               st_d = RTSA_RESP;
            end else if (is_lock && (tgt_dsfid ? dsfid_lk_w : afi_lk_w)) begin
               reserr_d = 1'b1;
               err_d = `RTSA_ERR_ALREADY_LOCKED;
               st_d = RTSA_RESP;
            end else begin
               // cells program now; reply held for the whole cycle
               nv_wr = 1'b1;
               tmr_start = 1'b1;
               st_d = RTSA_PROG;
            end
         end
         RTSA_PROG: begin
            if (tmr_done) begin
               st_d = RTSA_DONE;
            end
         end
         RTSA_DONE: begin
            // outcome decides success or failure code; only success goes back to ready
            if (!nv_ok) begin
               reserr_d = 1'b1;
               err_d = is_lock ? `RTSA_ERR_LOCK_FAIL : `RTSA_ERR_PROG_FAIL;
            end else begin
               pst_d = RTSA_PST_READY;
            end
            st_d = RTSA_RESP;
         end
         RTSA_RESP: begin
            rvalid_d = 1'b1;
            rflags_d = reserr_q ? `RTSA_RESP_FLAGS_ERR : `RTSA_RESP_FLAGS_OK;
            st_d = RTSA_IDLE;
         end
         default: st_d = RTSA_IDLE;
      endcase
   end

   // state registers only; every decision lives in the sequencer above
   always_ff @(posedge core_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         st_q <= RTSA_IDLE;
         pst_q <= RTSA_PST_READY;
         cmd_q <= 8'h00;
         data_q <= 8'h00;
         err_q <= 8'h00;
         reserr_q <= 1'b0;
         rflags_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         st_q <= st_d;
         pst_q <= pst_d;
         cmd_q <= cmd_d;
         data_q <= data_d;
         err_q <= err_d;
         reserr_q <= reserr_d;
         rflags_q <= rflags_d;
         rvalid_q <= rvalid_d;
      end
   end

   // registered outputs; mirror flops keep every port off logic
   logic [7:0] afi_o_q, dsfid_o_q, erro_q;
   logic afi_lk_o_q, dsfid_lk_o_q, busy_q, haserr_q;
   logic [7:0] afi_o_d, dsfid_o_d, erro_d;
   logic afi_lk_o_d, dsfid_lk_o_d, busy_d, haserr_d;
   // mirror next values; error code shown only in the answer cycle
   always_comb begin
      afi_o_d = afi_w;
      dsfid_o_d = dsfid_w;
      afi_lk_o_d = afi_lk_w;
      dsfid_lk_o_d = dsfid_lk_w;
      busy_d = (st_d != RTSA_IDLE);
      haserr_d = (st_q == RTSA_RESP) && reserr_q;
      erro_d = haserr_d ? err_q : 8'h00;
   end
   // mirror registers only
   always_ff @(posedge core_clk or negedge rst_core_n) begin
      if (!rst_core_n) begin
         afi_o_q <= 8'h00;
         dsfid_o_q <= 8'h00;
         afi_lk_o_q <= 1'b0;
         dsfid_lk_o_q <= 1'b0;
         busy_q <= 1'b0;
         haserr_q <= 1'b0;
         erro_q <= 8'h00;
      end else begin
         afi_o_q <= afi_o_d;
         dsfid_o_q <= dsfid_o_d;
         afi_lk_o_q <= afi_lk_o_d;
         dsfid_lk_o_q <= dsfid_lk_o_d;
         busy_q <= busy_d;
         haserr_q <= haserr_d;
         erro_q <= erro_d;
      end
   end

   assign busy = busy_q;
   assign resp_valid = rvalid_q;
   assign resp_flags = rflags_q;
   assign resp_has_err = haserr_q;
   assign resp_err_code = erro_q;
   assign proto_state = pst_q;
   assign afi_value = afi_o_q;
   assign dsfid_value = dsfid_o_q;
   assign afi_locked = afi_lk_o_q;
   assign dsfid_locked = dsfid_lk_o_q;
endmodule : rtsa_cmd_ctrl
`default_nettype wire

// [rtl/rtsa_regs.svh]
// constants for the tag identifier command block
`ifndef RTSA_REGS_SVH
`define RTSA_REGS_SVH
`define RTSA_CMD_RESET_READY 8'h26
`define RTSA_CMD_WRITE_AFI 8'h27
`define RTSA_CMD_LOCK_AFI 8'h28
`define RTSA_CMD_WRITE_DSFID 8'h29
`define RTSA_CMD_LOCK_DSFID 8'h2A
`define RTSA_ERR_OPTION 8'h03
`define RTSA_ERR_GENERIC 8'h0F
`define RTSA_ERR_ALREADY_LOCKED 8'h11
`define RTSA_ERR_LOCKED 8'h12
`define RTSA_ERR_PROG_FAIL 8'h13
`define RTSA_ERR_LOCK_FAIL 8'h14
`define RTSA_FLAG_ERROR_BIT 0
`define RTSA_FLAG_SELECT_BIT 4
`define RTSA_FLAG_ADDRESS_BIT 5
`define RTSA_FLAG_OPTION_BIT 6
`define RTSA_RESP_FLAGS_OK 8'h00
`define RTSA_RESP_FLAGS_ERR 8'h01
`define RTSA_AFI_RESET 8'h00
`define RTSA_DSFID_RESET 8'h00
// write cycle: nominal reply delay plus 18 periods of 302 us, in ns
`define RTSA_REPLY_DELAY_NS 320
`define RTSA_SLOT_NS 302000
`define RTSA_SLOT_COUNT 18
`define RTSA_CLK_NS 4
`define RTSA_WRITE_CYCLES ((`RTSA_REPLY_DELAY_NS + `RTSA_SLOT_COUNT * `RTSA_SLOT_NS) / `RTSA_CLK_NS)
`endif

// [rtl/rtsa_pkg.sv]
// types for the tag identifier command block
package rtsa_pkg;
   typedef enum logic [4:0] {
      RTSA_IDLE = 5'b00001,
      RTSA_EXEC = 5'b00010,
      RTSA_PROG = 5'b00100,
      RTSA_DONE = 5'b01000,
      RTSA_RESP = 5'b10000
   } rtsa_state_t;
   typedef enum logic [2:0] {
      RTSA_PST_READY = 3'b001,
      RTSA_PST_SELECTED = 3'b010,
      RTSA_PST_QUIET = 3'b100
   } rtsa_proto_t;
endpackage : rtsa_pkg

// [rtl/rtsa_wait_timer.sv]
// down counter timing the non-volatile write cycle
`timescale 1ns/1ps
`default_nettype none
module rtsa_wait_timer #(
   parameter int CYCLES = 1359080
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   output logic done
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] cnt_q, cnt_d;
   logic done_q, done_d;
   initial begin
      if (CYCLES < 1) $error("rtsa_wait_timer: CYCLES must be at least 1");
   end
   // load on start, pulse done when the count runs out
   always_comb begin
      cnt_d = cnt_q;
      done_d = 1'b0;
      if (start) begin
         cnt_d = W'(CYCLES);
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
         done_d = (cnt_q == W'(1));
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end
   assign done = done_q;
endmodule : rtsa_wait_timer
`default_nettype wire

// [rtl/rtsa_nv_store.sv]
// non-volatile identifier cells with lock bits, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "rtsa_regs.svh"
module rtsa_nv_store (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic sel_dsfid,
   input wire logic lock_op,
   input wire logic [7:0] wr_data,
   input wire logic fail_inject,
   output logic ok,
   output logic [7:0] afi,
   output logic [7:0] dsfid,
   output logic afi_locked,
   output logic dsfid_locked
);
   logic [7:0] afi_q, afi_d, dsfid_q, dsfid_d;
   logic afi_lk_q, afi_lk_d, dsfid_lk_q, dsfid_lk_d, ok_q, ok_d;
   // a failed program leaves the cell as it was
   always_comb begin
      afi_d = afi_q;
      dsfid_d = dsfid_q;
      afi_lk_d = afi_lk_q;
      dsfid_lk_d = dsfid_lk_q;
      ok_d = ok_q;
      if (wr_en) begin
         ok_d = !fail_inject;
         if (!fail_inject) begin
            if (lock_op && sel_dsfid) dsfid_lk_d = 1'b1;
            else if (lock_op) afi_lk_d = 1'b1;
            else if (sel_dsfid) dsfid_d = wr_data;
            else afi_d = wr_data;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         afi_q <= `RTSA_AFI_RESET;
         dsfid_q <= `RTSA_DSFID_RESET;
         afi_lk_q <= 1'b0;
         dsfid_lk_q <= 1'b0;
         ok_q <= 1'b0;
      end else begin
         afi_q <= afi_d;
         dsfid_q <= dsfid_d;
         afi_lk_q <= afi_lk_d;
         dsfid_lk_q <= dsfid_lk_d;
         ok_q <= ok_d;
      end
   end
   assign afi = afi_q;
   assign dsfid = dsfid_q;
   assign afi_locked = afi_lk_q;
   assign dsfid_locked = dsfid_lk_q;
   assign ok = ok_q;
endmodule : rtsa_nv_store
`default_nettype wire

// [tb/rtsa_cmd_ctrl_properties.sv]
// concurrent checks on the identifier command block ports
`timescale 1ns/1ps
`default_nettype none
module rtsa_cmd_ctrl_properties #(
   parameter int WRITE_CYCLES = 20
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic [7:0] req_flags,
   input wire logic [7:0] req_cmd,
   input wire logic req_uid_present,
   input wire logic [63:0] req_uid,
   input wire logic [63:0] own_uid,
   input wire logic busy,
   input wire logic resp_valid,
   input wire logic [7:0] resp_flags,
   input wire logic resp_has_err,
   input wire logic [7:0] resp_err_code,
   input wire logic [2:0] proto_state,
   input wire logic [7:0] afi_value,
   input wire logic [7:0] dsfid_value,
   input wire logic afi_locked,
   input wire logic dsfid_locked
);
   logic take;
   logic [7:0] cmd_q, cmd_d, afi_q, afi_d, dsf_q, dsf_d;
   logic [2:0] pst_q, pst_d;
   int cnt_q, cnt_d;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   assign take = req_valid && !busy;
   // snapshot at intake, so an error can be judged against the state before it
   always_comb begin
      cnt_d = busy ? cnt_q + 1 : 0;
      cmd_d = take ? req_cmd : cmd_q;
      afi_d = take ? afi_value : afi_q;
      dsf_d = take ? dsfid_value : dsf_q;
      pst_d = take ? proto_state : pst_q;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 0;
         cmd_q <= 8'h00;
         afi_q <= 8'h00;
         dsf_q <= 8'h00;
         pst_q <= 3'h1;
      end else begin
         cnt_q <= cnt_d;
         cmd_q <= cmd_d;
         afi_q <= afi_d;
         dsf_q <= dsf_d;
         pst_q <= pst_d;
      end
   end
   AST_OK_FLAGS: assert property (resp_valid && !resp_has_err |-> resp_flags == 8'h00 && resp_err_code == 8'h00) else $error("success flags wrong");
   AST_ERR_FLAGS: assert property (resp_valid && resp_has_err |-> resp_flags == 8'h01) else $error("error flags wrong");
   AST_WRITE_CODES: assert property (resp_valid && resp_has_err && cmd_q inside {8'h27, 8'h29} |-> resp_err_code inside {8'h03, 8'h0F, 8'h12, 8'h13}) else $error("bad write code");
   AST_LOCK_CODES: assert property (resp_valid && resp_has_err && cmd_q inside {8'h28, 8'h2A} |-> resp_err_code inside {8'h03, 8'h0F, 8'h11, 8'h14}) else $error("bad lock code");
   AST_RTR_CODES: assert property (resp_valid && resp_has_err && cmd_q == 8'h26 |-> resp_err_code inside {8'h03, 8'h0F}) else $error("bad reset code");
   AST_AFI_FROZEN: assert property (afi_locked |=> afi_locked && $stable(afi_value)) else $error("afi lock broken");
   AST_DSFID_FROZEN: assert property (dsfid_locked |=> dsfid_locked && $stable(dsfid_value)) else $error("dsfid lock broken");
   AST_PROG_WAIT: assert property (resp_valid && !resp_has_err && cmd_q inside {8'h27, 8'h28, 8'h29, 8'h2A} |-> cnt_q >= WRITE_CYCLES) else $error("early answer");
   AST_RTR_READY: assert property (resp_valid && !resp_has_err && cmd_q == 8'h26 |-> ##[0:2] proto_state == 3'b001) else $error("not ready");
   AST_SILENT: assert property (take && req_flags[5] && req_uid_present && req_uid != own_uid |=> !resp_valid [*8]) else $error("foreign answer");
   AST_ERR_KEEPS: assert property (resp_valid && resp_has_err |-> afi_value == afi_q && dsfid_value == dsf_q && proto_state == pst_q) else $error("error changed state");
   // main scenarios reached
   cover property (resp_valid && resp_err_code == 8'h12);
   cover property (resp_valid && resp_err_code == 8'h11);
   cover property (resp_valid && !resp_has_err && cmd_q == 8'h27);
endmodule : rtsa_cmd_ctrl_properties
bind rtsa_cmd_ctrl rtsa_cmd_ctrl_properties #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.*);
`default_nettype wire

// [tb/rtsa_reader_model.sv]
// reader model handing decoded requests to the tag
`timescale 1ns/1ps
`default_nettype none
module rtsa_reader_model (
   input wire logic core_clk,
   input wire logic busy,
   output logic req_valid,
   output logic [7:0] req_flags,
   output logic [7:0] req_cmd,
   output logic req_uid_present,
   output logic [63:0] req_uid,
   output logic [7:0] req_data,
   output logic req_data_present,
   output logic req_frame_err
);
   initial begin
      req_valid = 1'b0;
      {req_flags, req_cmd, req_data} = 24'h0;
      {req_uid_present, req_data_present, req_frame_err} = 3'h0;
      req_uid = 64'h0;
   end
   // one request per call, launched and ended on falling edges
   task automatic send(input logic [7:0] fl, input logic [7:0] cmd, input logic up,
                       input logic [63:0] uid, input logic [7:0] dat, input logic dp,
                       input logic fe);
      // no modulation while the tag programs its cells
      while (busy) @(negedge core_clk);
      @(negedge core_clk);
      req_valid = 1'b1;
      req_flags = fl;
      req_cmd = cmd;
      req_uid_present = up;
      req_uid = uid;
      req_data = dat;
      req_data_present = dp;
      req_frame_err = fe;
      @(negedge core_clk);
      req_valid = 1'b0;
      // stale data and uid show junk so nothing leans on their old values
      req_data = ~req_data;
      req_uid = ~req_uid;
   endtask : send
endmodule : rtsa_reader_model
`default_nettype wire

// [tb/rf_tag_state_afi_dsfid_cmds_test.sv]
// self-checking bench for the identifier command block
`timescale 1ns/1ps
`default_nettype none
module rf_tag_state_afi_dsfid_cmds_test;
   import rtsa_pkg::*;
   localparam int WC = 20;
   localparam logic [63:0] UID = 64'hA5C3_0123_4567_89AB;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic nv_fail_inject = 1'b0;
   logic [63:0] own_uid = UID;
   logic req_valid, req_uid_present, req_data_present, req_frame_err;
   logic [7:0] req_flags, req_cmd, req_data;
   logic [63:0] req_uid;
   logic busy, resp_valid, resp_has_err, afi_locked, dsfid_locked;
   logic [7:0] resp_flags, resp_err_code, afi_value, dsfid_value;
   logic [2:0] proto_state;
   int error_cnt = 0;
   int compares = 0;
   int lat;
   always #2 core_clk = ~core_clk;
   rtsa_reader_model rdr (.*);
   rtsa_cmd_ctrl #(.WRITE_CYCLES(WC)) uut (.*);
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk8
   // one request, answer judged; exp 00h means success
   task automatic req(input logic [7:0] fl, input logic [7:0] cmd, input logic up,
                      input logic dp, input logic [7:0] dat, input logic fe,
                      input logic [7:0] exp);
      lat = 0;
      rdr.send(fl, cmd, up, UID, dat, dp, fe);
      chk8({7'h00, busy}, 8'h01, "busy");
      while (resp_valid !== 1'b1 && lat < 200) begin
         @(negedge core_clk);
         lat++;
      end
      chk8({7'h00, busy}, 8'h00, "idle");
      chk8({7'h00, resp_valid}, 8'h01, "answer");
      chk8(resp_flags, {7'h00, exp != 8'h00}, "flags");
      chk8({7'h00, resp_has_err}, {7'h00, exp != 8'h00}, "has_err");
      chk8(resp_err_code, exp, "code");
   endtask : req
   // request that must stay unanswered for 20 cycles
   task automatic quiet(input logic [7:0] fl, input logic [7:0] cmd, input logic up,
                        input logic [63:0] uid, input string what);
      int n = 0;
      rdr.send(fl, cmd, up, uid, 8'h00, 1'b0, 1'b0);
      repeat (20) begin
         @(negedge core_clk);
         if (resp_valid !== 1'b0) n++;
      end
      chk8(8'(n), 8'h00, what);
   endtask : quiet
   task automatic t_ready;
      chk8({5'h00, proto_state}, 8'h01, "proto");
      req(8'h00, 8'h26, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00);
      req(8'h20, 8'h26, 1'b1, 1'b0, 8'h00, 1'b0, 8'h00);
      req(8'h40, 8'h26, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00);
      chk8({5'h00, proto_state}, 8'h01, "proto");
      req(8'h00, 8'h26, 1'b0, 1'b0, 8'h00, 1'b1, 8'h0F);
      // addressed without a uid cannot match, so it stays silent
      quiet(8'h20, 8'h26, 1'b0, UID, "no uid");
      quiet(8'h20, 8'h26, 1'b1, ~UID, "silence");
   endtask : t_ready
   task automatic t_write;
      req(8'h00, 8'h27, 1'b0, 1'b1, 8'h5A, 1'b0, 8'h00);
      chk8({7'h00, lat >= WC}, 8'h01, "wait");
      chk8(afi_value, 8'h5A, "afi");
      req(8'h20, 8'h29, 1'b1, 1'b1, 8'hC3, 1'b0, 8'h00);
      chk8(dsfid_value, 8'hC3, "dsfid");
      req(8'h00, 8'h27, 1'b0, 1'b0, 8'h77, 1'b0, 8'h0F);
      nv_fail_inject = 1'b1;
      req(8'h00, 8'h29, 1'b0, 1'b1, 8'h3C, 1'b0, 8'h13);
      nv_fail_inject = 1'b0;
      chk8(dsfid_value, 8'hC3, "dsfid kept");
   endtask : t_write
   task automatic t_lock;
      nv_fail_inject = 1'b1;
      req(8'h00, 8'h28, 1'b0, 1'b0, 8'h00, 1'b0, 8'h14);
      nv_fail_inject = 1'b0;
      chk8({7'h00, afi_locked}, 8'h00, "afi lock");
      req(8'h00, 8'h28, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00);
      chk8({7'h00, afi_locked}, 8'h01, "afi lock");
      req(8'h00, 8'h28, 1'b0, 1'b0, 8'h00, 1'b0, 8'h11);
      req(8'h00, 8'h27, 1'b0, 1'b1, 8'h99, 1'b0, 8'h12);
      chk8(afi_value, 8'h5A, "afi kept");
      req(8'h00, 8'h2A, 1'b0, 1'b0, 8'h00, 1'b0, 8'h00);
      chk8({7'h00, dsfid_locked}, 8'h01, "dsfid lock");
      req(8'h00, 8'h2A, 1'b0, 1'b0, 8'h00, 1'b0, 8'h11);
      req(8'h00, 8'h29, 1'b0, 1'b1, 8'h11, 1'b0, 8'h12);
      chk8(dsfid_value, 8'hC3, "dsfid kept");
   endtask : t_lock
   task automatic stop_test;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   // 17 requests of at most some 30 cycles each; generous margin
   initial begin
      repeat (3000) @(posedge core_clk);
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (5) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      t_ready();
      t_write();
      t_lock();
      stop_test();
   end
endmodule : rf_tag_state_afi_dsfid_cmds_test
`default_nettype wire
